//--- src/dap_top.sv
/*
  Dual audio port clock routing: register file, pin direction control for the
  two serial ports, master-mode clock generation and converter clock routing.
  Assumes one 100 MHz core clock; master clocks and port pins arrive
  asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module dap_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic master_clock_a,
  input wire logic master_clock_b,
  input wire logic first_bit_clock_in,
  output logic first_bit_clock_out,
  output logic first_bit_clock_oe,
  input wire logic first_frame_clock_in,
  output logic first_frame_clock_out,
  output logic first_frame_clock_oe,
  input wire logic second_bit_clock_in,
  output logic second_bit_clock_out,
  output logic second_bit_clock_oe,
  input wire logic second_frame_clock_in,
  output logic second_frame_clock_out,
  output logic second_frame_clock_oe,
  input wire logic first_dac_serial_input,
  input wire logic second_dac_serial_input,
  output logic first_dac_data,
  output logic second_dac_data,
  output logic adc_clock,
  output logic adc_bit_clock,
  output logic adc_frame_clock,
  output logic [1:0] adc_format,
  output logic adc_format_valid,
  output logic first_dac_clock,
  output logic first_dac_bit_clock,
  output logic first_dac_frame_clock,
  output logic [1:0] first_dac_format,
  output logic second_dac_clock,
  output logic second_dac_bit_clock,
  output logic second_dac_frame_clock,
  output logic [1:0] second_dac_format,
  output logic system_clock
);
  // ==========================================================
  // registers
  logic [7:0] sys_ctrl;
  logic [7:0] first_port_control;
  logic [7:0] second_port_control;
  logic [7:0] adc_clocking;
  logic [7:0] first_dac_clocking;
  logic [7:0] second_dac_clocking;

  logic [7:0] next_rdata;

  // reserved bits are masked off on write, so they always hold default zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_ctrl <= dap_pkg::RST_SYS;
      first_port_control <= dap_pkg::RST_PORT;
      second_port_control <= dap_pkg::RST_PORT;
      adc_clocking <= dap_pkg::RST_CONV;
      first_dac_clocking <= dap_pkg::RST_CONV;
      second_dac_clocking <= dap_pkg::RST_CONV;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        dap_pkg::OFS_SYS_CTRL: sys_ctrl <= reg_wdata & dap_pkg::MASK_SYS;
        dap_pkg::OFS_FIRST_PORT: first_port_control <= reg_wdata & dap_pkg::MASK_PORT;
        dap_pkg::OFS_SECOND_PORT: second_port_control <= reg_wdata & dap_pkg::MASK_PORT;
        dap_pkg::OFS_ADC_CLK: adc_clocking <= reg_wdata & dap_pkg::MASK_CONV;
        dap_pkg::OFS_FIRST_DAC_CLK: first_dac_clocking <= reg_wdata & dap_pkg::MASK_CONV;
        dap_pkg::OFS_SECOND_DAC_CLK: second_dac_clocking <= reg_wdata & dap_pkg::MASK_CONV;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // field decode
  logic first_port_role;
  logic second_port_role;
  logic first_port_clock_hiz;
  logic second_port_clock_hiz;
  logic system_clock_select;

  assign first_port_role = first_port_control[dap_pkg::POS_ROLE];
  assign second_port_role = second_port_control[dap_pkg::POS_ROLE];
  assign first_port_clock_hiz = sys_ctrl[dap_pkg::POS_HIZ_FIRST];
  assign second_port_clock_hiz = sys_ctrl[dap_pkg::POS_HIZ_SECOND];
  assign system_clock_select = sys_ctrl[dap_pkg::POS_SYS_SEL];

  // ==========================================================
  // synchronisers: pins pass two flops before any logic reads them
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pins;

  assign pins = {master_clock_a, master_clock_b, first_bit_clock_in, first_frame_clock_in,
                 second_bit_clock_in, second_frame_clock_in,
                 first_dac_serial_input, second_dac_serial_input};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  logic mclk_a_s;
  logic mclk_b_s;
  logic bclk1_in_s;
  logic fclk1_in_s;
  logic bclk2_in_s;
  logic fclk2_in_s;

  assign {mclk_a_s, mclk_b_s, bclk1_in_s, fclk1_in_s, bclk2_in_s, fclk2_in_s} =
         sync_b[NSYNC-1:2];

  // data pins are inputs in every configuration; no driver exists for them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_dac_data <= 1'b0;
      second_dac_data <= 1'b0;
    end
    else
    begin
      first_dac_data <= sync_b[1];
      second_dac_data <= sync_b[0];
    end
  end

  // ==========================================================
  // master clock edge detect, on the synchronised copies only
  logic mclk_a_d;
  logic mclk_b_d;
  logic mclk_a_en;
  logic mclk_b_en;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mclk_a_d <= 1'b0;
      mclk_b_d <= 1'b0;
    end
    else
    begin
      mclk_a_d <= mclk_a_s;
      mclk_b_d <= mclk_b_s;
    end
  end

  assign mclk_a_en = mclk_a_s & ~mclk_a_d;
  assign mclk_b_en = mclk_b_s & ~mclk_b_d;

  // source and divider picks; each port divides by its source clock's divider
  function automatic logic pick(input logic sel, input logic a, input logic b);
    pick = sel ? b : a;
  endfunction : pick

  function automatic logic [1:0] pick2(input logic sel, input logic [1:0] a,
                                       input logic [1:0] b);
    pick2 = sel ? b : a;
  endfunction : pick2

  logic first_src;
  logic second_src;
  logic [1:0] clock_a_divider;
  logic [1:0] clock_b_divider;

  assign first_src = first_port_control[dap_pkg::POS_SRC];
  assign second_src = second_port_control[dap_pkg::POS_SRC];
  assign clock_a_divider = first_port_control[dap_pkg::POS_DIV_LO +: 2];
  assign clock_b_divider = second_port_control[dap_pkg::POS_DIV_LO +: 2];

  // ==========================================================
  // master-mode generators; held idle in slave mode, so rate is ignored
  logic gen1_bclk;
  logic gen1_fclk;
  logic gen2_bclk;
  logic gen2_fclk;

  dap_port_clkgen u_gen1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(first_port_role),
    .rate(first_port_control[dap_pkg::POS_RATE]),
    .divider(pick2(first_src, clock_a_divider, clock_b_divider)),
    .mclk_en(pick(first_src, mclk_a_en, mclk_b_en)),
    .bit_clock(gen1_bclk),
    .frame_clock(gen1_fclk)
  );

  dap_port_clkgen u_gen2 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(second_port_role),
    .rate(second_port_control[dap_pkg::POS_RATE]),
    .divider(pick2(second_src, clock_a_divider, clock_b_divider)),
    .mclk_en(pick(second_src, mclk_a_en, mclk_b_en)),
    .bit_clock(gen2_bclk),
    .frame_clock(gen2_fclk)
  );

  // ==========================================================
  // pin direction: drive only as master with hiz clear
  always_comb
  begin
    first_bit_clock_oe = first_port_role & ~first_port_clock_hiz;
    first_frame_clock_oe = first_port_role & ~first_port_clock_hiz;

    second_bit_clock_oe = second_port_role & ~second_port_clock_hiz;
    second_frame_clock_oe = second_port_role & ~second_port_clock_hiz;
  end

  assign first_bit_clock_out = gen1_bclk;
  assign first_frame_clock_out = gen1_fclk;

  assign second_bit_clock_out = gen2_bclk;
  assign second_frame_clock_out = gen2_fclk;

  // port clocks seen internally: own generator as master, pins as slave
  logic port1_bclk;
  logic port1_fclk;
  logic port2_bclk;
  logic port2_fclk;

  assign port1_bclk = pick(first_port_role, bclk1_in_s, gen1_bclk);
  assign port1_fclk = pick(first_port_role, fclk1_in_s, gen1_fclk);
  assign port2_bclk = pick(second_port_role, bclk2_in_s, gen2_bclk);
  assign port2_fclk = pick(second_port_role, fclk2_in_s, gen2_fclk);

  // ==========================================================
  // converter routing, registered outputs
  logic adc_psel;
  logic dac1_psel;
  logic dac2_psel;

  assign adc_psel = adc_clocking[dap_pkg::POS_CONV_PORT];
  assign dac1_psel = first_dac_clocking[dap_pkg::POS_CONV_PORT];
  assign dac2_psel = second_dac_clocking[dap_pkg::POS_CONV_PORT];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_clock <= 1'b0;
      adc_bit_clock <= 1'b0;
      adc_frame_clock <= 1'b0;
      adc_format <= dap_pkg::FMT_LJ24;
      adc_format_valid <= 1'b1;

      first_dac_clock <= 1'b0;
      first_dac_bit_clock <= 1'b0;
      first_dac_frame_clock <= 1'b0;
      first_dac_format <= dap_pkg::FMT_LJ24;

      second_dac_clock <= 1'b0;
      second_dac_bit_clock <= 1'b0;
      second_dac_frame_clock <= 1'b0;
      second_dac_format <= dap_pkg::FMT_LJ24;

      system_clock <= 1'b0;
    end
    else
    begin
      adc_clock <= pick(adc_clocking[dap_pkg::POS_CONV_CLK], mclk_a_s, mclk_b_s);
      adc_bit_clock <= pick(adc_psel, port1_bclk, port2_bclk);
      adc_frame_clock <= pick(adc_psel, port1_fclk, port2_fclk);
      adc_format <= adc_clocking[dap_pkg::POS_FMT_LO +: 2];
      // codes 10 and 11 are reserved; flagged so the transmitter stays quiet
      adc_format_valid <= (adc_clocking[dap_pkg::POS_FMT_LO +: 2] == dap_pkg::FMT_LJ24) ||
                          (adc_clocking[dap_pkg::POS_FMT_LO +: 2] == dap_pkg::FMT_I2S24);

      first_dac_clock <= pick(first_dac_clocking[dap_pkg::POS_CONV_CLK],
                              mclk_a_s, mclk_b_s);
      first_dac_bit_clock <= pick(dac1_psel, port1_bclk, port2_bclk);
      first_dac_frame_clock <= pick(dac1_psel, port1_fclk, port2_fclk);
      first_dac_format <= first_dac_clocking[dap_pkg::POS_FMT_LO +: 2];

      second_dac_clock <= pick(second_dac_clocking[dap_pkg::POS_CONV_CLK],
                               mclk_a_s, mclk_b_s);
      second_dac_bit_clock <= pick(dac2_psel, port1_bclk, port2_bclk);
      second_dac_frame_clock <= pick(dac2_psel, port1_fclk, port2_fclk);
      second_dac_format <= second_dac_clocking[dap_pkg::POS_FMT_LO +: 2];

      // software must keep this pointing at a running clock
      system_clock <= pick(system_clock_select, mclk_a_s, mclk_b_s);
    end
  end

  // ==========================================================
  // read port: data stand the cycle after the read strobe only
  logic [7:0] status;

  assign status = {4'h0, first_port_role & first_port_clock_hiz,
                   second_port_role & second_port_clock_hiz, gen1_fclk, gen2_fclk};

  always_comb
  begin
    case (reg_addr)
      dap_pkg::OFS_SYS_CTRL: next_rdata = sys_ctrl;
      dap_pkg::OFS_FIRST_PORT: next_rdata = first_port_control;
      dap_pkg::OFS_SECOND_PORT: next_rdata = second_port_control;
      dap_pkg::OFS_ADC_CLK: next_rdata = adc_clocking;
      dap_pkg::OFS_FIRST_DAC_CLK: next_rdata = first_dac_clocking;
      dap_pkg::OFS_SECOND_DAC_CLK: next_rdata = second_dac_clocking;
      dap_pkg::OFS_STATUS: next_rdata = status;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end
endmodule : dap_top
`default_nettype wire

//--- src/dap_pkg.sv
/*
  Shared constants for the dual audio port clock routing block: register offsets,
  field positions, reset values, speed-mode and format codes, divider timing.
  Assumes a single 100 MHz core clock and a plain address/strobe register port.
*/
// Contract
// - master port with clock hiz set floats its bit and frame clocks
// - slave port keeps bit and frame clock pins as inputs always
// - both DAC serial data pins are always inputs
// - first port role: 0 slave, 1 master driving clocks
// - second port role: 0 slave, 1 master, independent of first
// - first port rate: 0 single-speed, 1 double-speed in master mode
// - second port rate: 0 single-speed, 1 double-speed in master mode
// - clock A divider codes 00..11 divide by 1, 1.5, 2, 3
// - clock B divider codes 00..11 divide by 1, 1.5, 2, 3
// - first port clock source: 0 clock A, 1 clock B
// - second port clock source: 0 clock A, 1 clock B
// - ADC clock source: 0 clock A, 1 clock B
// - ADC port source: 0 first port, 1 second port
// - ADC format: 00 left-justified 24, 01 I2S 24, others reserved
// - first DAC clock source: 0 clock A, 1 clock B
// - first DAC port source: 0 first port, 1 second port
// - first DAC format: LJ24, I2S24, RJ16, RJ24 for codes 00..11
// - second DAC clock source: 0 clock A, 1 clock B
// - second DAC port source: 0 first port, 1 second port
// - second DAC format: LJ24, I2S24, RJ16, RJ24 for codes 00..11
package dap_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SYS_CTRL = 8'h02;
  localparam logic [7:0] OFS_FIRST_PORT = 8'h03;
  localparam logic [7:0] OFS_SECOND_PORT = 8'h04;
  localparam logic [7:0] OFS_ADC_CLK = 8'h06;
  localparam logic [7:0] OFS_FIRST_DAC_CLK = 8'h07;
  localparam logic [7:0] OFS_SECOND_DAC_CLK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ==========================================================
  // port control fields
  localparam int POS_ROLE = 7;
  localparam int POS_RATE = 4;
  localparam int POS_DIV_LO = 2;
  localparam int POS_SRC = 0;
  // system control fields
  localparam int POS_SYS_SEL = 3;
  localparam int POS_HIZ_FIRST = 1;
  localparam int POS_HIZ_SECOND = 0;
  // converter clocking fields
  localparam int POS_CONV_CLK = 6;
  localparam int POS_CONV_PORT = 4;
  localparam int POS_FMT_LO = 0;
  // writable masks, reserved bits stay zero
  localparam logic [7:0] MASK_PORT = 8'h9D;
  localparam logic [7:0] MASK_CONV = 8'h53;
  localparam logic [7:0] MASK_SYS = 8'h0B;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_CONV = 8'h00;
  localparam logic [7:0] RST_SYS = 8'h00;
  // ==========================================================
  // codes
  localparam logic [1:0] FMT_LJ24 = 2'h0;
  localparam logic [1:0] FMT_I2S24 = 2'h1;
  localparam logic [1:0] FMT_RJ16 = 2'h2;
  localparam logic [1:0] FMT_RJ24 = 2'h3;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_1P5 = 2'h1;
  localparam logic [1:0] DIV_2 = 2'h2;
  localparam logic [1:0] DIV_3 = 2'h3;
  // ==========================================================
  // frame timing: bit clock = divided master clock / BCLK_RATIO, frame = 64 bits
  localparam int BCLK_RATIO_SSM = 4;
  localparam int BCLK_RATIO_DSM = 2;
  localparam int BITS_PER_FRAME = 64;
  localparam logic [6:0] HALF_FRAME = 7'h20;
endpackage : dap_pkg

//--- src/dap_port_clkgen.sv
/*
  Master-mode clock generator for one serial audio port: divides the selected
  master clock enable by 1, 1.5, 2 or 3, then makes bit and frame clocks.
  Assumes master clock edges arrive as one-cycle enables in the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dap_port_clkgen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic rate,
  input wire logic [1:0] divider,
  input wire logic mclk_en,
  output logic bit_clock,
  output logic frame_clock
);
  // ==========================================================
  // fractional divider: adds 2 per master edge, fires on reaching 2*ratio
  logic [2:0] acc;
  logic div_en;
  logic [2:0] limit;
  logic [1:0] bdiv;
  logic [5:0] bits;

  always_comb
  begin
    case (divider)
      dap_pkg::DIV_1: limit = 3'h2;
      dap_pkg::DIV_1P5: limit = 3'h3;
      dap_pkg::DIV_2: limit = 3'h4;
      default: limit = 3'h6;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc <= 3'h0;
      div_en <= 1'b0;
    end
    else if (!run)
    begin
      acc <= 3'h0;
      div_en <= 1'b0;
    end
    else if (mclk_en)
    begin
      // 1.5 averages: two output edges per three master edges
      if (acc + 3'h2 >= limit)
      begin
        acc <= 3'(acc + 3'h2 - limit);
        div_en <= 1'b1;
      end
      else
      begin
        acc <= 3'(acc + 3'h2);
        div_en <= 1'b0;
      end
    end
    else
      div_en <= 1'b0;
  end

  // ==========================================================
  // bit clock: half period is 2 divided edges in single speed, 1 in double
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bdiv <= 2'h0;
      bit_clock <= 1'b0;
      bits <= 6'h0;
      frame_clock <= 1'b0;
    end
    else if (!run)
    begin
      bdiv <= 2'h0;
      bit_clock <= 1'b0;
      bits <= 6'h0;
      frame_clock <= 1'b0;
    end
    else if (div_en)
    begin
      if (rate || bdiv == 2'h1)
      begin
        bdiv <= 2'h0;
        bit_clock <= ~bit_clock;
        if (bit_clock)
        begin
          bits <= 6'(bits + 6'h1);
          if (bits == 6'(dap_pkg::HALF_FRAME - 7'h1) || bits == 6'h3F)
            frame_clock <= ~frame_clock;
        end
      end
      else
        bdiv <= 2'(bdiv + 2'h1);
    end
  end
endmodule : dap_port_clkgen
`default_nettype wire

//--- tb/dap_sva.sv
/*
  Checker for dap_top: pin direction, readback, routing and format relations.
  Assumes it is bound to dap_top from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module dap_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic master_clock_a,
  input wire logic first_bit_clock_out,
  input wire logic first_bit_clock_oe,
  input wire logic first_frame_clock_oe,
  input wire logic second_bit_clock_oe,
  input wire logic second_frame_clock_oe,
  input wire logic first_dac_serial_input,
  input wire logic first_dac_data,
  input wire logic adc_clock,
  input wire logic [1:0] adc_format,
  input wire logic adc_format_valid
);
  // ==========
  // shadow registers
  logic [7:0] sys;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] adcc;
  logic [2:0] age;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys <= 8'h00;
      p1 <= 8'h00;
      p2 <= 8'h00;
      adcc <= 8'h00;
    end
    else if (reg_write)
    begin
      if (reg_addr == dap_pkg::OFS_SYS_CTRL) sys <= reg_wdata & dap_pkg::MASK_SYS;
      if (reg_addr == dap_pkg::OFS_FIRST_PORT) p1 <= reg_wdata & dap_pkg::MASK_PORT;
      if (reg_addr == dap_pkg::OFS_SECOND_PORT) p2 <= reg_wdata & dap_pkg::MASK_PORT;
      if (reg_addr == dap_pkg::OFS_ADC_CLK) adcc <= reg_wdata & dap_pkg::MASK_CONV;
    end
  end
  // synchroniser history is not trusted until it has refilled
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  // ==========
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_FIRST_OE: assert property (
    first_bit_clock_oe == (p1[7] & ~sys[1]) && first_frame_clock_oe == first_bit_clock_oe)
    else $error("first port pin drive wrong");
  AST_SECOND_OE: assert property (
    second_bit_clock_oe == (p2[7] & ~sys[0]) && second_frame_clock_oe == second_bit_clock_oe)
    else $error("second port pin drive wrong");
  AST_SLAVE_QUIET: assert property (
    (!p1[7]) [*3] |-> !first_bit_clock_out)
    else $error("slave port generator running");
  AST_RDATA_PORT: assert property (
    $past(reg_read) && $past(reg_addr) == dap_pkg::OFS_FIRST_PORT |-> reg_rdata == p1)
    else $error("port register readback wrong");
  AST_ADC_CLK_A: assert property (
    $rose(master_clock_a) && !adcc[6] |-> ##[1:4] (adc_clock || adcc[6]))
    else $error("adc clock not following clock a");
  AST_FMT_VALID: assert property (
    adc_format_valid == !adc_format[1])
    else $error("adc format valid flag wrong");
  AST_ADC_FMT: assert property (
    $stable(adcc) [*2] |-> adc_format == adcc[1:0])
    else $error("adc format not following register");
  AST_DATA_IN: assert property (
    age == 3'h7 |-> first_dac_data == $past(first_dac_serial_input, 3))
    else $error("dac data input path wrong");
  COV_MASTER: cover property (first_bit_clock_oe);
  COV_HIZ: cover property (p1[7] && sys[1]);
  COV_I2S: cover property (adc_format[0]);
endmodule : dap_sva
`default_nettype wire

//--- tb/dap_partner.sv
/*
  Far-side audio processor model: clock master on a slave port, data source.
  Assumes the bench resolves each pin from the device output enables.
*/
`timescale 1ns/1ps
`default_nettype none
module dap_partner #(
  parameter int HALF = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic bit_clock,
  output logic frame_clock,
  output logic data
);
  // ==========
  // bit clock stands still low and frame clock holds its level while the device owns the port
  int cnt;
  logic [4:0] bits;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      bits <= 5'h00;
      bit_clock <= 1'b0;
      frame_clock <= 1'b0;
      data <= 1'b0;
    end
    else if (!run)
    begin
      cnt <= 0;
      bit_clock <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      bit_clock <= ~bit_clock;
      if (bit_clock)
      begin
        bits <= bits + 5'h01;
        data <= ~data ^ bits[1];
        // 32 bits per half frame, 64 per frame
        if (bits == 5'h1F) frame_clock <= ~frame_clock;
      end
    end
    else
      cnt <= cnt + 1;
  end
endmodule : dap_partner
`default_nettype wire

//--- tb/dap_top_tb_top.sv
/*
  Bench for dap_top: register port, pin directions, divider and clock routing.
  Assumes dap_pkg, dap_sva and dap_partner are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module dap_top_tb_top;
  localparam int W = 1920;
  localparam int D2 [4] = '{2, 3, 4, 6};
  localparam logic [23:0] ROWS [8] = '{24'h020B0B, 24'h039D9D, 24'h049D9D, 24'h065151,
    24'h075353, 24'h085353, 24'h031010, 24'h09FF00};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic mca = 1'b0;
  logic mcb = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] adc_format, first_dac_format, second_dac_format;
  logic b1o, b1e, f1o, f1e, b2o, b2e, f2o, f2e, pb1, pf1, pd1, pb2, pf2, pd2;
  logic adc_valid, adcc, adcb, c1, c1b, c2, c2b, sysc, b1p, f1p, b2p, f2p;
  logic [8:0] mon;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  // ==========
  // master clocks: 8 and 12 core cycles, both derived from the one cycle counter
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    mca <= (cyc % 8) < 4;
    mcb <= (cyc % 12) < 6;
  end
  assign b1p = b1e ? b1o : pb1;
  assign f1p = f1e ? f1o : pf1;
  assign b2p = b2e ? b2o : pb2;
  assign f2p = f2e ? f2o : pf2;
  assign mon = {sysc, c2, c1, adcc, c2b, c1b, adcb, b2o, b1o};
  dap_top i_dap_top (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .master_clock_a(mca), .master_clock_b(mcb),
    .first_bit_clock_in(b1p), .first_bit_clock_out(b1o), .first_bit_clock_oe(b1e),
    .first_frame_clock_in(f1p), .first_frame_clock_out(f1o), .first_frame_clock_oe(f1e),
    .second_bit_clock_in(b2p), .second_bit_clock_out(b2o), .second_bit_clock_oe(b2e),
    .second_frame_clock_in(f2p), .second_frame_clock_out(f2o), .second_frame_clock_oe(f2e),
    .first_dac_serial_input(pd1), .second_dac_serial_input(pd2),
    .first_dac_data(), .second_dac_data(), .adc_clock(adcc), .adc_bit_clock(adcb),
    .adc_frame_clock(), .adc_format(adc_format), .adc_format_valid(adc_valid),
    .first_dac_clock(c1), .first_dac_bit_clock(c1b), .first_dac_frame_clock(),
    .first_dac_format(first_dac_format), .second_dac_clock(c2), .second_dac_bit_clock(c2b),
    .second_dac_frame_clock(), .second_dac_format(second_dac_format), .system_clock(sysc));
  dap_partner #(.HALF(10)) i_dap_partner (.core_clk(core_clk), .rst_n(rst_n), .run(!b1e),
    .bit_clock(pb1), .frame_clock(pf1), .data(pd1));
  dap_partner #(.HALF(7)) i_dap_partner_b (.core_clk(core_clk), .rst_n(rst_n), .run(!b2e),
    .bit_clock(pb2), .frame_clock(pf2), .data(pd2));
  // ==========
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // rising edges of one monitored clock over W cycles, two edges of slack for phase
  task automatic near(input int idx, input int exp);
    int n;
    logic prev;
    n = 0;
    prev = mon[idx];
    repeat (W)
    begin
      @(posedge core_clk);
      if (mon[idx] && !prev) n++;
      prev = mon[idx];
    end
    check((n - exp <= 2 && exp - n <= 2) ? 8'(exp) : 8'(n), 8'(exp));
  endtask : near
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // ==========
  // main sequence
  initial
  begin : main
    logic [7:0] v;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ROWS[i][23:16], v);
      check(v, 8'h00);
    end
    check({3'h0, adc_valid, b1e, f1e, b2e, f2e}, 8'h10);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], v);
      check(v, ROWS[i][7:0]);
    end
    for (int i = 0; i < 6; i++)
      wr(ROWS[i][23:16], 8'h00);
    $display("register table done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h06, 8'(i % 2));
      wr(8'h07, 8'(i));
      wr(8'h08, 8'(i));
      repeat (3) @(posedge core_clk);
      check({adc_format, first_dac_format, second_dac_format, adc_valid, 1'b0},
        {1'b0, i[0], i[1:0], i[1:0], 1'b1, 1'b0});
    end
    $display("format test done");
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h02, {6'h00, i[1:0]});
      wr(8'h03, {i[2], 7'h00});
      wr(8'h04, {i[3], 7'h00});
      @(posedge core_clk);
      check({4'h0, b1e, f1e, b2e, f2e},
        {4'h0, {2{i[2] & !i[1]}}, {2{i[3] & !i[0]}}});
    end
    wr(8'h02, 8'h00);
    $display("direction test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h03, 8'h90 | 8'(i << 2));
      near(0, W / (8 * D2[i]));
      wr(8'h04, 8'h91 | 8'(i << 2));
      near(1, W / (12 * D2[i]));
    end
    wr(8'h03, 8'h80);
    near(0, W / 32);
    wr(8'h04, 8'h81);
    near(1, W / 48);
    wr(8'h04, 8'h90);
    near(1, W / 16);
    wr(8'h03, 8'h91);
    near(0, W / 24);
    $display("divider test done");
    wr(8'h03, 8'h10);
    near(0, 0);
    wr(8'h04, 8'h91);
    for (int c = 0; c < 3; c++)
      for (int j = 0; j < 2; j++)
      begin
        wr(8'(6 + c), j ? 8'h50 : 8'h00);
        near(2 + c, j ? 80 : 96);
        near(5 + c, j ? 160 : 240);
      end
    near(8, 240);
    wr(8'h02, 8'h08);
    near(8, 160);
    $display("routing test done");
    complete_run();
  end
  initial
  begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule : dap_top_tb_top
bind dap_top dap_sva i_dap_sva (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .master_clock_a(master_clock_a), .first_bit_clock_out(first_bit_clock_out),
  .first_bit_clock_oe(first_bit_clock_oe), .first_frame_clock_oe(first_frame_clock_oe),
  .second_bit_clock_oe(second_bit_clock_oe), .second_frame_clock_oe(second_frame_clock_oe),
  .first_dac_serial_input(first_dac_serial_input), .first_dac_data(first_dac_data),
  .adc_clock(adc_clock), .adc_format(adc_format), .adc_format_valid(adc_format_valid));
`default_nettype wire
